// *** pdc_pkg.sv ***
// Package for the programmable dithered clock register block and its bus master
package pdc_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_DIV_CTRL = 8'h02;
  localparam logic [7:0] ADDR_FINE_STEP = 8'h08;
  localparam logic [7:0] ADDR_BUS_NV = 8'h0D;
  localparam logic [7:0] ADDR_COARSE_BAND = 8'h0E;
  localparam logic [7:0] ADDR_BAND_COPY = 8'h37;
  localparam logic [7:0] CMD_COMMIT_NV = 8'h3F;
  // Reset (factory) values
  localparam logic [15:0] DIV_CTRL_RST = 16'h6000;
  localparam logic [15:0] FINE_STEP_RST = 16'h7D00;
  localparam logic [7:0] BUS_NV_RST = 8'hF0;
  localparam logic [4:0] BAND_DEFAULT = 5'h12;
  // Field positions inside the divider/dither word, the fine step word and the bus NV byte
  localparam int RATE_HI = 15;
  localparam int RATE_LO = 14;
  localparam int DEPTH_HI = 13;
  localparam int DEPTH_LO = 11;
  localparam int IDLE_LOW_BIT = 10;
  localparam int EXP_HI = 9;
  localparam int EXP_LO = 6;
  localparam int FINE_SHIFT = 6;
  localparam int NV_DEFER_BIT = 3;
  // Reads-as-one masks for the byte registers
  localparam logic [7:0] BUS_NV_ONES = 8'hF0;
  localparam logic [7:0] BAND_ONES = 8'hE0;
  // Divider limits and dither rates
  localparam logic [3:0] EXP_MAX = 4'h8;
  localparam logic [1:0] RATE_8192 = 2'h0;
  localparam logic [1:0] RATE_4096 = 2'h1;
  localparam logic [1:0] RATE_2048 = 2'h2;
  localparam int RATE_DIV_8192 = 8192;
  localparam int RATE_DIV_4096 = 4096;
  localparam int RATE_DIV_2048 = 2048;
  // Startup oscillator cycles before the output may run
  localparam int STARTUP_CYCLES = 512;
  // EEPROM store time (arbitrary small default)
  localparam int NV_WRITE_CYCLES = 64;
  // Access kinds on the request port
  typedef enum logic [1:0] {
    PDC_OP_READ = 2'b00,
    PDC_OP_WRITE = 2'b01,
    PDC_OP_CMD = 2'b10
  } pdc_op_t;
endpackage : pdc_pkg

// *** pdc_if.sv ***
// Interface joining the register block and the bus master
`timescale 1ns/10ps
interface pdc_if;
  logic req; // Access request, held until done
  pdc_pkg::pdc_op_t op; // Read, write or command
  logic [7:0] addr; // Register address or command code
  logic two_byte; // Access moves both bytes of a word
  logic [15:0] wdata; // Write data, first of two bytes in the top, a single byte in the low lane
  logic [15:0] rdata; // Read data
  logic done; // Access finished
  logic nack; // Access refused
  modport dev (input req, input op, input addr, input two_byte, input wdata, output rdata, output done, output nack);
  modport mst (output req, output op, output addr, output two_byte, output wdata, input rdata, input done, input nack);
endinterface : pdc_if

// *** pdc_regs.sv ***
// Register, nonvolatile and output control end of the dithered clock
// Summary of operation
// - Divider word at 02h, two-byte access
// - Dither rate from osc divided 8192/4096/2048
// - Depth codes 0.5,1,2,4,8 percent; others reserved
// - Dither only while spread pin high
// - Idle output low if bit set, else HiZ
// - Divide by 2^(exp+1), exp clamped to 8
// - Fine step at 08h, two bytes, 5kHz each
// - Fine step left-justified, shifted up six
// - Coarse band at 0Eh selects oscillator range
// - 37h read-only returns factory band default
// - Master adds offset to band copy
// - Defer bit chooses immediate or deferred EEPROM store
// - Power cycle restores registers from EEPROM
// - Bus-address register write always stored at once
// - Three select bits form slave address
// - Command 3Fh commits all registers to EEPROM
// - Low output gate disables output, osc runs
// - Low halt input stops oscillator, powers down
// - Output enabling synchronised, no truncated pulse
// - Output held off for 512 startup cycles
`timescale 1ns/10ps
module pdc_regs #(
  parameter int NV_CYCLES = pdc_pkg::NV_WRITE_CYCLES,
  parameter logic [4:0] FACTORY_BAND = pdc_pkg::BAND_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rstn,
  pdc_if.dev bus,
  input wire logic power_on, // Supply present; low models a power cycle
  input wire logic spread_enable_pin,
  input wire logic out_gate_pin,
  input wire logic osc_halt_n_pin,
  output logic clk_out_o,
  output logic clk_out_oe,
  output logic dither_on,
  output logic [1:0] dither_rate_sel,
  output logic [2:0] dither_depth_sel,
  output logic dither_tick,
  output logic [9:0] fine_step,
  output logic [4:0] coarse_band,
  output logic [2:0] bus_addr_sel
);
  // Volatile registers
  logic [15:0] div_ctrl_r;
  logic [15:0] fine_r;
  logic [7:0] bus_nv_r;
  logic [4:0] band_r;
  // EEPROM image
  logic [15:0] nv_div_r;
  logic [15:0] nv_fine_r;
  logic [7:0] nv_bus_r;
  logic [4:0] nv_band_r;
  // Store timer and access handshake
  logic [15:0] nv_cnt_r;
  logic done_r;
  logic nack_r;
  logic [15:0] rdata_r;
  // Divider, dither and startup state
  logic [8:0] div_cnt_r;
  logic [12:0] rate_cnt_r;
  logic [9:0] start_cnt_r;
  logic out_run_r;
  logic out_q_r;

  // Decode of the request
  wire nv_busy = (nv_cnt_r != 16'h0000);
  wire take = bus.req && !done_r;
  wire is_wr = take && !nv_busy && (bus.op == pdc_pkg::PDC_OP_WRITE);
  wire is_cmd = take && !nv_busy && (bus.op == pdc_pkg::PDC_OP_CMD) && (bus.addr == pdc_pkg::CMD_COMMIT_NV);
  wire wr_div = is_wr && (bus.addr == pdc_pkg::ADDR_DIV_CTRL);
  wire wr_fine = is_wr && (bus.addr == pdc_pkg::ADDR_FINE_STEP);
  wire wr_bus = is_wr && (bus.addr == pdc_pkg::ADDR_BUS_NV);
  wire wr_band = is_wr && (bus.addr == pdc_pkg::ADDR_COARSE_BAND);
  wire nv_defer = bus_nv_r[pdc_pkg::NV_DEFER_BIT];
  // Immediate store unless deferred; address register always stored
  wire store_now = (wr_div || wr_fine || wr_band) && !nv_defer || wr_bus || is_cmd;
  wire [7:0] wbyte = bus.two_byte ? bus.wdata[15:8] : bus.wdata[7:0];

  // Read mux, byte registers in the low lane
  logic [15:0] rd_mux;
  always_comb begin
    unique case (bus.addr)
      pdc_pkg::ADDR_DIV_CTRL: rd_mux = div_ctrl_r;
      pdc_pkg::ADDR_FINE_STEP: rd_mux = fine_r;
      pdc_pkg::ADDR_BUS_NV: rd_mux = {8'h00, bus_nv_r | pdc_pkg::BUS_NV_ONES};
      pdc_pkg::ADDR_COARSE_BAND: rd_mux = {8'h00, pdc_pkg::BAND_ONES | {3'h0, band_r}};
      pdc_pkg::ADDR_BAND_COPY: rd_mux = {11'h000, FACTORY_BAND};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Handshake: answer one cycle after a request, refuse while storing
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      done_r <= 1'b0;
      nack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      done_r <= take;
      nack_r <= take && nv_busy;
      if (take && bus.op == pdc_pkg::PDC_OP_READ) begin
        rdata_r <= rd_mux;
      end
    end
  end
  assign bus.done = done_r;
  assign bus.nack = nack_r;
  assign bus.rdata = rdata_r;

  // Word write value: low six bits always stored as zero
  wire [15:0] wword = {bus.wdata[15:pdc_pkg::FINE_SHIFT], 6'h00};

  // Volatile registers: reloaded from EEPROM at power-up
  always_ff @(posedge ref_clk) begin
    if (!rstn || !power_on) begin
      div_ctrl_r <= nv_div_r;
      fine_r <= nv_fine_r;
      bus_nv_r <= nv_bus_r;
      band_r <= nv_band_r;
    end else begin
      if (wr_div) div_ctrl_r <= {bus.wdata[15:6], 6'h00};
      if (wr_fine) fine_r <= {bus.wdata[15:6], 6'h00};
      if (wr_bus) bus_nv_r <= wbyte;
      if (wr_band) band_r <= wbyte[4:0];
    end
  end

  // EEPROM image and store timer; only factory reset and the store path write it
  always_ff @(posedge ref_clk) begin
    // Reset with the supply off stands for factory programming of the image
    if (!rstn && !power_on) begin
      nv_div_r <= pdc_pkg::DIV_CTRL_RST;
      nv_fine_r <= pdc_pkg::FINE_STEP_RST;
      nv_bus_r <= pdc_pkg::BUS_NV_RST;
      nv_band_r <= FACTORY_BAND;
    end else if (store_now) begin
      nv_div_r <= wr_div ? wword : (is_cmd ? div_ctrl_r : nv_div_r);
      nv_fine_r <= wr_fine ? wword : (is_cmd ? fine_r : nv_fine_r);
      nv_bus_r <= wr_bus ? (wbyte | pdc_pkg::BUS_NV_ONES) : (is_cmd ? bus_nv_r : nv_bus_r);
      nv_band_r <= wr_band ? wbyte[4:0] : (is_cmd ? band_r : nv_band_r);
    end
    if (!rstn) begin
      nv_cnt_r <= 16'h0000;
    end else if (store_now) begin
      nv_cnt_r <= 16'(NV_CYCLES);
    end else if (nv_busy) begin
      nv_cnt_r <= nv_cnt_r - 16'h0001;
    end
  end

  // Field decode
  wire [3:0] exp_raw = div_ctrl_r[pdc_pkg::EXP_HI:pdc_pkg::EXP_LO];
  wire [3:0] exp_eff = (exp_raw > pdc_pkg::EXP_MAX) ? pdc_pkg::EXP_MAX : exp_raw;
  wire [1:0] rate = div_ctrl_r[pdc_pkg::RATE_HI:pdc_pkg::RATE_LO];
  wire [12:0] rate_top = (rate == pdc_pkg::RATE_8192) ? 13'(pdc_pkg::RATE_DIV_8192 - 1) :
                         (rate == pdc_pkg::RATE_2048) ? 13'(pdc_pkg::RATE_DIV_2048 - 1) :
                         13'(pdc_pkg::RATE_DIV_4096 - 1);
  wire idle_drive_low = div_ctrl_r[pdc_pkg::IDLE_LOW_BIT];
  wire osc_run = osc_halt_n_pin;
  wire [8:0] div_top = 9'((16'h0001 << exp_eff) - 16'h0001);
  assign dither_rate_sel = rate;
  assign dither_depth_sel = div_ctrl_r[pdc_pkg::DEPTH_HI:pdc_pkg::DEPTH_LO];
  assign dither_on = spread_enable_pin && osc_run;
  assign fine_step = fine_r[15:pdc_pkg::FINE_SHIFT];
  assign coarse_band = band_r;
  assign bus_addr_sel = bus_nv_r[2:0];

  // Dither triangle step tick at the selected rate
  always_ff @(posedge ref_clk) begin
    if (!rstn || !osc_run) begin
      rate_cnt_r <= 13'h0000;
      dither_tick <= 1'b0;
    end else begin
      dither_tick <= (rate_cnt_r >= rate_top);
      rate_cnt_r <= (rate_cnt_r >= rate_top) ? 13'h0000 : rate_cnt_r + 13'h0001;
    end
  end

  // Startup count and output divider
  always_ff @(posedge ref_clk) begin
    if (!rstn || !osc_run || !power_on) begin
      start_cnt_r <= 10'h000;
      div_cnt_r <= 9'h000;
      out_q_r <= 1'b0;
      out_run_r <= 1'b0;
    end else begin
      if (start_cnt_r < 10'(pdc_pkg::STARTUP_CYCLES)) start_cnt_r <= start_cnt_r + 10'h001;
      if (exp_eff == 4'h0) begin
        out_q_r <= ~out_q_r;
      end else if (div_cnt_r >= div_top) begin
        div_cnt_r <= 9'h000;
        out_q_r <= ~out_q_r;
      end else begin
        div_cnt_r <= div_cnt_r + 9'h001;
      end
      // Gate changes only while output low, so no short pulse
      if (!out_q_r) begin
        out_run_r <= out_gate_pin && (start_cnt_r >= 10'(pdc_pkg::STARTUP_CYCLES));
      end
    end
  end

  // Pin drive: running clock, held low, or released
  assign clk_out_o = out_run_r & out_q_r;
  assign clk_out_oe = out_run_r | idle_drive_low;
endmodule : pdc_regs

// *** pdc_master.sv ***
// Bus master end that programs the dithered clock registers
`timescale 1ns/10ps
module pdc_master (
  input wire logic ref_clk,
  input wire logic rstn,
  pdc_if.mst bus,
  input wire logic start, // Pulse: begin one access
  input wire logic [1:0] op,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic band_change, // Pulse: do read-add-write of band
  input wire logic [4:0] band_offset, // Signed offset from factory band
  output logic busy,
  output logic [15:0] rdata,
  output logic refused
);
  typedef enum logic [1:0] {
    PDC_M_IDLE = 2'b00,
    PDC_M_ACC = 2'b01,
    PDC_M_BAND_RD = 2'b10,
    PDC_M_BAND_WR = 2'b11
  } pdc_mst_t;
  pdc_mst_t st_r;
  logic [1:0] op_r;
  logic [7:0] addr_r;
  logic [15:0] wdata_r;
  logic [4:0] off_r;
  logic req_r;

  // Word registers take two bytes
  wire word_addr = (addr_r == pdc_pkg::ADDR_DIV_CTRL) || (addr_r == pdc_pkg::ADDR_FINE_STEP);
  assign bus.req = req_r && !bus.done;
  assign bus.op = pdc_pkg::pdc_op_t'(op_r);
  assign bus.addr = addr_r;
  assign bus.two_byte = word_addr;
  assign bus.wdata = wdata_r;
  assign busy = (st_r != PDC_M_IDLE);

  // Sequencer
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_r <= PDC_M_IDLE;
      req_r <= 1'b0;
      op_r <= 2'b00;
      addr_r <= 8'h00;
      wdata_r <= 16'h0000;
      off_r <= 5'h00;
      rdata <= 16'h0000;
      refused <= 1'b0;
    end else begin
      unique case (st_r)
        PDC_M_IDLE: begin
          if (band_change) begin
            op_r <= pdc_pkg::PDC_OP_READ;
            addr_r <= pdc_pkg::ADDR_BAND_COPY;
            off_r <= band_offset;
            req_r <= 1'b1;
            st_r <= PDC_M_BAND_RD;
          end else if (start) begin
            op_r <= op;
            addr_r <= addr;
            wdata_r <= wdata;
            req_r <= 1'b1;
            st_r <= PDC_M_ACC;
          end
        end
        PDC_M_ACC: begin
          if (bus.done) begin
            req_r <= 1'b0;
            rdata <= bus.rdata;
            refused <= bus.nack;
            st_r <= PDC_M_IDLE;
          end
        end
        PDC_M_BAND_RD: begin
          if (bus.done && bus.nack) begin
            req_r <= 1'b0;
            refused <= 1'b1;
            st_r <= PDC_M_IDLE;
          end else if (bus.done) begin
            op_r <= pdc_pkg::PDC_OP_WRITE;
            addr_r <= pdc_pkg::ADDR_COARSE_BAND;
            wdata_r <= {11'h000, 5'(bus.rdata[4:0] + off_r)};
            st_r <= PDC_M_BAND_WR;
          end
        end
        PDC_M_BAND_WR: begin
          if (bus.done) begin
            req_r <= 1'b0;
            refused <= bus.nack;
            st_r <= PDC_M_IDLE;
          end
        end
      endcase
    end
  end
endmodule : pdc_master

// *** pdc_bus_props.sv ***
// Concurrent checks on the register link between bus master and register block
`timescale 1ns/10ps
module pdc_bus_props #(
  parameter int NV_CYCLES = pdc_pkg::NV_WRITE_CYCLES,
  parameter logic [4:0] FACTORY_BAND = pdc_pkg::BAND_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req,
  input wire pdc_pkg::pdc_op_t op,
  input wire logic [7:0] addr,
  input wire logic two_byte,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic done,
  input wire logic nack
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Accepted read reply
  wire rd_ok = done && !nack && op == pdc_pkg::PDC_OP_READ;
  // Accepted access that always starts an EEPROM store
  wire st_bus = op == pdc_pkg::PDC_OP_WRITE && addr == pdc_pkg::ADDR_BUS_NV;
  wire st_cmd = op == pdc_pkg::PDC_OP_CMD && addr == pdc_pkg::CMD_COMMIT_NV;
  wire st_go = done && !nack && (st_bus || st_cmd);
  wire word = addr == pdc_pkg::ADDR_DIV_CTRL || addr == pdc_pkg::ADDR_FINE_STEP;
  // Cycles surely left in a store, kept short of the end to allow latency slack
  logic [7:0] busy_r;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      busy_r <= 8'h00;
    end else if (st_go) begin
      busy_r <= 8'(NV_CYCLES - 2);
    end else if (busy_r != 8'h00) begin
      busy_r <= busy_r - 8'h01;
    end
  end
  AST_DONE_ANSWER: assert property (req && !done |=> done) else $error("request not answered");
  AST_DONE_PULSE: assert property (done |=> !done) else $error("done longer than one cycle");
  AST_NACK_QUAL: assert property (nack |-> done) else $error("nack without done");
  AST_REQ_DROP: assert property (done |-> !req) else $error("request high while done");
  AST_WORD_PAIR: assert property (req && op != pdc_pkg::PDC_OP_CMD && word |-> two_byte)
    else $error("word access not two bytes");
  AST_FINE_JUST: assert property (rd_ok && addr == pdc_pkg::ADDR_FINE_STEP |-> rdata[5:0] == 6'h00)
    else $error("fine step low bits not zero");
  AST_DIV_LOW: assert property (rd_ok && addr == pdc_pkg::ADDR_DIV_CTRL |-> rdata[5:0] == 6'h00)
    else $error("divider word low bits not zero");
  AST_BAND_COPY: assert property (rd_ok && addr == pdc_pkg::ADDR_BAND_COPY |-> rdata[4:0] == FACTORY_BAND)
    else $error("band copy wrong");
  AST_STORE_REFUSE: assert property (done && busy_r != 8'h00 |-> nack) else $error("access during store");
  AST_RDATA_HOLD: assert property ($changed(rdata) |-> done && op == pdc_pkg::PDC_OP_READ)
    else $error("read data moved without read");
endmodule : pdc_bus_props

// *** programmable_dithered_clock_regs_tb.sv ***
// Testbench driving both ends of the dithered clock register link
`timescale 1ns/10ps
module programmable_dithered_clock_regs_tb;
  localparam int NV = 8; // Short store time
  localparam logic [4:0] FB = 5'h0B; // Arbitrary factory band
  localparam logic [1:0] RD = pdc_pkg::PDC_OP_READ;
  localparam logic [1:0] WR = pdc_pkg::PDC_OP_WRITE;
  localparam logic [7:0] A_DIV = pdc_pkg::ADDR_DIV_CTRL;
  localparam logic [7:0] A_FIN = pdc_pkg::ADDR_FINE_STEP;
  localparam logic [7:0] A_BUS = pdc_pkg::ADDR_BUS_NV;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic power_on = 1'b0;
  logic spread = 1'b1;
  logic gate = 1'b1;
  logic halt_n = 1'b1;
  logic start = 1'b0;
  logic band_change = 1'b0;
  logic [1:0] op = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [4:0] band_offset = 5'h00;
  logic busy, refused, clk_out_o, clk_out_oe, dither_on, dither_tick;
  logic [15:0] rdata;
  logic [1:0] rate;
  logic [2:0] depth, bsel;
  logic [9:0] fine;
  logic [4:0] band;
  int n_errors = 0;
  int tests_run = 0;
  int i;
  // Link between the two ends
  pdc_if i_pdc_if();
  pdc_regs #(.NV_CYCLES(NV), .FACTORY_BAND(FB)) i_pdc_regs (.ref_clk(ref_clk), .rstn(rstn), .bus(i_pdc_if.dev),
    .power_on(power_on), .spread_enable_pin(spread), .out_gate_pin(gate), .osc_halt_n_pin(halt_n),
    .clk_out_o(clk_out_o), .clk_out_oe(clk_out_oe), .dither_on(dither_on), .dither_rate_sel(rate),
    .dither_depth_sel(depth), .dither_tick(dither_tick), .fine_step(fine), .coarse_band(band), .bus_addr_sel(bsel));
  pdc_master i_pdc_master (.ref_clk(ref_clk), .rstn(rstn), .bus(i_pdc_if.mst), .start(start), .op(op),
    .addr(addr), .wdata(wdata), .band_change(band_change), .band_offset(band_offset), .busy(busy),
    .rdata(rdata), .refused(refused));
  pdc_bus_props #(.NV_CYCLES(NV), .FACTORY_BAND(FB)) i_pdc_bus_props (.ref_clk(ref_clk), .rstn(rstn),
    .req(i_pdc_if.req), .op(i_pdc_if.op), .addr(i_pdc_if.addr), .two_byte(i_pdc_if.two_byte),
    .wdata(i_pdc_if.wdata), .rdata(i_pdc_if.rdata), .done(i_pdc_if.done), .nack(i_pdc_if.nack));
  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Compare one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Report and stop
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // Bounded wait for the master to go idle
  task automatic wait_idle();
    for (i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      if (busy === 1'b0) return;
    end
    n_errors++;
    end_sim();
  endtask : wait_idle
  // Bounded wait for a dither tick, cycles waited in i
  task automatic wait_tick();
    for (i = 1; i < 9000; i++) begin
      @(negedge ref_clk);
      if (dither_tick === 1'b1) return;
    end
    n_errors++;
    end_sim();
  endtask : wait_tick
  // One access through the master
  task automatic acc(input logic [1:0] o, input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    op = o;
    addr = a;
    wdata = d;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    wait_idle();
  endtask : acc
  // Supply drop and return
  task automatic pcycle();
    power_on = 1'b0;
    repeat (3) @(negedge ref_clk);
    power_on = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask : pcycle
  // Main sequence
  initial begin
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    power_on = 1'b1;
    for (i = 0; i < 1000 && clk_out_oe !== 1'b1; i++) @(negedge ref_clk);
    check({clk_out_oe, 15'(i > 500)}, 16'h8001);
    acc(RD, A_DIV, 16'h0000);
    check(rdata, pdc_pkg::DIV_CTRL_RST);
    acc(RD, A_FIN, 16'h0000);
    check(rdata, pdc_pkg::FINE_STEP_RST);
    acc(RD, pdc_pkg::ADDR_COARSE_BAND, 16'h0000);
    check(rdata[7:0], {3'b111, FB});
    acc(RD, pdc_pkg::ADDR_BAND_COPY, 16'h0000);
    check(rdata[4:0], FB);
    check({rate, depth, bsel, fine}, {2'h1, 3'h4, 3'h0, 10'h1F4});
    acc(WR, A_BUS, 16'h000D);
    acc(RD, A_BUS, 16'h0000);
    check(refused, 1'b1);
    repeat (12) @(negedge ref_clk);
    acc(RD, A_BUS, 16'h0000);
    check({rdata[7:0], 5'h00, bsel}, 16'hFD05);
    acc(WR, A_DIV, 16'hBE7F);
    acc(RD, A_DIV, 16'h0000);
    check({refused, rdata}, 17'h0BE40);
    check({rate, depth}, {2'h2, 3'h7});
    check(dither_on, 1'b1);
    spread = 1'b0;
    repeat (3) @(negedge ref_clk);
    check(dither_on, 1'b0);
    spread = 1'b1;
    for (int r = 0; r < 3; r++) begin
      acc(WR, A_DIV, {r[1:0], 14'h0000});
      wait_tick();
      wait_tick();
      check(16'(i), 16'(8192 >> r));
    end
    // Exponent above the limit divides as the limit: measure one high phase
    acc(WR, A_DIV, 16'h03C0);
    for (i = 0; i < 600 && clk_out_o !== 1'b0; i++) @(negedge ref_clk);
    for (i = 0; i < 600 && clk_out_o !== 1'b1; i++) @(negedge ref_clk);
    for (i = 0; i < 600 && clk_out_o !== 1'b0; i++) @(negedge ref_clk);
    check(i, 1 << pdc_pkg::EXP_MAX);
    acc(WR, A_DIV, 16'h8400);
    gate = 1'b0;
    repeat (20) @(negedge ref_clk);
    check({clk_out_oe, clk_out_o}, 2'b10);
    gate = 1'b1;
    halt_n = 1'b0;
    repeat (20) @(negedge ref_clk);
    check({clk_out_oe, clk_out_o}, 2'b10);
    acc(WR, A_DIV, 16'h8000);
    repeat (4) @(negedge ref_clk);
    check(clk_out_oe, 1'b0);
    halt_n = 1'b1;
    acc(WR, A_FIN, 16'hA1C0);
    acc(RD, A_FIN, 16'h0000);
    check({fine, rdata}, {10'h287, 16'hA1C0});
    @(negedge ref_clk);
    band_offset = 5'h1E;
    band_change = 1'b1;
    @(negedge ref_clk);
    band_change = 1'b0;
    wait_idle();
    check(band, FB - 5'h02);
    pcycle();
    acc(RD, A_DIV, 16'h0000);
    check(rdata, pdc_pkg::DIV_CTRL_RST);
    check({band, bsel}, {FB, 3'h5});
    acc(WR, A_FIN, 16'h4600);
    acc(pdc_pkg::PDC_OP_CMD, pdc_pkg::CMD_COMMIT_NV, 16'h0000);
    acc(RD, A_FIN, 16'h0000);
    check(refused, 1'b1);
    repeat (12) @(negedge ref_clk);
    pcycle();
    acc(RD, A_FIN, 16'h0000);
    check(rdata, 16'h4600);
    acc(WR, A_BUS, 16'h0000);
    repeat (12) @(negedge ref_clk);
    acc(WR, A_DIV, 16'h0040);
    acc(RD, A_DIV, 16'h0000);
    check(refused, 1'b1);
    end_sim();
  end
endmodule : programmable_dithered_clock_regs_tb
